// ---- src/tcp_pkg.sv ----
// Constants and types for the timer channel pair (capture, PWM, one-shot)
//------------------------------------------------------------------------------
// Contract
// - Count clock is prescaled fclk; only channel 5 may pick sub or low-speed clock.
// - Unit logic is clocked only while the unit clock enable bit is 1; register writes and the stop bit still take effect while it is 0.
// - Capture mode counts up; width is period times (capture+1) plus 10000H times overflow.
// - Overflow flag records one overflow only; more make the result invalid.
// - Capture interrupts on each valid edge, and on start if start interrupt select set.
// - A valid input edge copies the counter into the channel data register.
// - Writing 1 to a channel's start bit starts counting in the configured mode.
// - Writing 1 to a channel's stop bit halts counting on that channel.
// - PWM counts both channels down; period is period times (master data plus one).
// - PWM master interrupts at start and after reaching 0000H; slave after its 0000H.
// - With timer output disabled, the pin follows the software output level bit.
// - Slave output is active high when polarity bit is 0, active low when 1.
// - Master is an even channel 0 to 6; its slave is higher, at most 7.
// - One-shot active width equals slave data times the count clock period.
// - One-shot master loads and starts on input edge or software start bit.
// - One-shot slave loads and counts on the count clock after master reaches 0000h.
// - One-shot master interrupts on the count clock after reaching 0000H.
// - Master and slave live counters are readable by software at any time.
//------------------------------------------------------------------------------
package tcp_pkg;

	// -------------------------------------------------------------------------
	// Channel placement
	// -------------------------------------------------------------------------
	localparam int unsigned MASTER_IDX = 4;
	localparam int unsigned SLAVE_IDX  = 5;
	localparam int unsigned SLOW_IDX   = 5;

	// -------------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------------
	localparam logic [7:0] OFF_PERIPH_EN  = 8'h00;
	localparam logic [7:0] OFF_START_TRIG = 8'h04;
	localparam logic [7:0] OFF_STOP_TRIG  = 8'h08;
	localparam logic [7:0] OFF_MODE       = 8'h0C;
	localparam logic [7:0] OFF_MDATA      = 8'h10;
	localparam logic [7:0] OFF_SDATA      = 8'h14;
	localparam logic [7:0] OFF_MCOUNT     = 8'h18;
	localparam logic [7:0] OFF_SCOUNT     = 8'h1C;
	localparam logic [7:0] OFF_OUTCTRL    = 8'h20;
	localparam logic [7:0] OFF_STATUS     = 8'h24;

	// -------------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------------
	localparam int unsigned MODE_LSB     = 0;
	localparam int unsigned STARTIRQ_BIT = 2;
	localparam int unsigned EDGE_BIT     = 3;
	localparam int unsigned MCLK_LSB     = 4;
	localparam int unsigned SCLK_LSB     = 9;
	localparam int unsigned OLVL_BIT     = 0;
	localparam int unsigned OEN_BIT      = 1;
	localparam int unsigned OPOL_BIT     = 2;

	// -------------------------------------------------------------------------
	// Reset values and counter constants
	// -------------------------------------------------------------------------
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [13:0] MODE_RST = 14'h0000;
	localparam logic [15:0] DATA_RST = 16'hFFFF;
	localparam logic [4:0]  CSEL_SUB = 5'h10;
	localparam logic [4:0]  CSEL_LOW = 5'h11;

	// -------------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MD_CAPTURE = 2'h0,
		MD_PWM     = 2'h1,
		MD_ONESHOT = 2'h2,
		MD_RSVD    = 2'h3
	} tcp_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN  = 3'b100
	} tcp_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tcp_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tcp_apb_rsp_t;

	typedef struct packed {
		logic [4:0] sclk;
		logic [4:0] mclk;
		logic       rising;
		logic       start_irq;
		tcp_mode_t  mode;
	} tcp_cfg_t;

endpackage

// ---- src/tcp_timer.sv ----
// Timer channel pair: interval capture, PWM and one-shot, with APB registers
`timescale 1ns/100ps

module tcp_timer (
	input  wire logic                  CLOCK,
	input  wire logic                  RESETN,
	input  wire tcp_pkg::tcp_apb_req_t APB_REQ,
	output tcp_pkg::tcp_apb_rsp_t      APB_RSP,
	input  wire logic                  SUB_TICK,
	input  wire logic                  LOW_TICK,
	input  wire logic                  TIMER_IN,
	output logic                       TIMER_OUT,
	output logic                       TIMER_OUT_EN,
	output logic                       MASTER_IRQ,
	output logic                       SLAVE_IRQ
);

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------
	function automatic logic sel_tick(
		input logic [4:0]  sel,
		input logic [15:0] pre,
		input logic        slow_ok,
		input logic        sub,
		input logic        low
	);
		logic [15:0] mask;
		mask = (16'h0001 << sel[3:0]) - 16'h0001;
		if (sel == tcp_pkg::CSEL_SUB && slow_ok) begin
			sel_tick = sub;
		end else if (sel == tcp_pkg::CSEL_LOW && slow_ok) begin
			sel_tick = low;
		end else if (sel[4]) begin
			sel_tick = 1'b1;
		end else begin
			sel_tick = ((pre & mask) == mask);
		end
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	function automatic logic at_zero(input logic [15:0] c);
		at_zero = (c == tcp_pkg::CNT_ZERO);
	endfunction

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	tcp_pkg::tcp_cfg_t   cfg_q;
	tcp_pkg::tcp_state_t state_q;
	logic        unit_clock_enable_q;
	logic [15:0] mdata_q;
	logic [15:0] sdata_q;
	logic [15:0] mcount_q;
	logic [15:0] scount_q;
	logic        out_level_q;
	logic        out_enable_q;
	logic        polarity_q;
	logic        slave_active_q;
	logic        slave_run_q;
	logic        ovf_run_q;
	logic        overflow_flag_q;
	logic [15:0] pre_q;
	logic        in_prev_q;
	logic [31:0] rdata_q;
	logic        slverr_q;
	logic        mirq_q;
	logic        sirq_q;
	logic        wr_en;
	logic        rd_setup;
	logic        start_wr;
	logic        stop_wr;
	logic        edge_seen;
	logic        mtick;
	logic        stick;
	logic        mapped;
	logic        is_cap;
	logic        is_pwm;
	logic        is_one;
	logic        m_zero;
	logic        s_zero;

	// ------------------------------------------------------------------------
	// Bus strobes
	// ------------------------------------------------------------------------
	assign wr_en    = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	assign rd_setup = APB_REQ.psel && !APB_REQ.penable;
	assign mapped   = (APB_REQ.paddr[1:0] == 2'h0) && (APB_REQ.paddr <= tcp_pkg::OFF_STATUS);

	// Either channel bit of the pair acts on the pair
	assign start_wr = wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_START_TRIG)
		&& unit_clock_enable_q
		&& (APB_REQ.pwdata[tcp_pkg::MASTER_IDX] || APB_REQ.pwdata[tcp_pkg::SLAVE_IDX]);
	assign stop_wr  = wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_STOP_TRIG)
		&& (APB_REQ.pwdata[tcp_pkg::MASTER_IDX] || APB_REQ.pwdata[tcp_pkg::SLAVE_IDX]);

	assign is_cap = (cfg_q.mode == tcp_pkg::MD_CAPTURE);
	assign is_pwm = (cfg_q.mode == tcp_pkg::MD_PWM);
	assign is_one = (cfg_q.mode == tcp_pkg::MD_ONESHOT);

	// ------------------------------------------------------------------------
	// Counter end decodes
	// ------------------------------------------------------------------------
	assign m_zero = at_zero(mcount_q);
	assign s_zero = at_zero(scount_q);

	// ------------------------------------------------------------------------
	// Unit clock gating and prescaler
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			unit_clock_enable_q <= 1'b0;
		end else if (wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_PERIPH_EN)) begin
			unit_clock_enable_q <= APB_REQ.pwdata[0];
		end
	end

	// Prescaler held at zero while the unit is off; the enable term in mtick and stick keeps the count clocks off
	always_ff @(posedge CLOCK) begin
		if (!RESETN || !unit_clock_enable_q) begin
			pre_q <= tcp_pkg::CNT_ZERO;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	assign mtick = unit_clock_enable_q
		&& sel_tick(cfg_q.mclk, pre_q, tcp_pkg::MASTER_IDX == tcp_pkg::SLOW_IDX,
			SUB_TICK, LOW_TICK);
	assign stick = unit_clock_enable_q
		&& sel_tick(cfg_q.sclk, pre_q, tcp_pkg::SLAVE_IDX == tcp_pkg::SLOW_IDX,
			SUB_TICK, LOW_TICK);

	// ------------------------------------------------------------------------
	// Input edge detection
	// ------------------------------------------------------------------------
	// Sampler sleeps with the unit; a start needs two enabled cycles, so no stale edge
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			in_prev_q <= 1'b0;
		end else if (unit_clock_enable_q) begin
			in_prev_q <= TIMER_IN;
		end
	end

	assign edge_seen = unit_clock_enable_q
		&& (cfg_q.rising ? (TIMER_IN && !in_prev_q) : (!TIMER_IN && in_prev_q));

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			cfg_q <= tcp_pkg::tcp_cfg_t'(tcp_pkg::MODE_RST);
		end else if (wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_MODE)
			&& state_q == tcp_pkg::ST_IDLE) begin
			cfg_q <= tcp_pkg::tcp_cfg_t'(APB_REQ.pwdata[13:0]);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			out_level_q  <= 1'b0;
			out_enable_q <= 1'b0;
			polarity_q   <= 1'b0;
		end else if (wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_OUTCTRL)) begin
			// Level bit only latches while output is disabled
			if (!out_enable_q) begin
				out_level_q <= APB_REQ.pwdata[tcp_pkg::OLVL_BIT];
			end
			out_enable_q <= APB_REQ.pwdata[tcp_pkg::OEN_BIT];
			polarity_q   <= APB_REQ.pwdata[tcp_pkg::OPOL_BIT];
		end
	end

	// Slave data: software sets the active width
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			sdata_q <= tcp_pkg::DATA_RST;
		end else if (wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_SDATA)) begin
			sdata_q <= APB_REQ.pwdata[15:0];
		end
	end

	// Master data: period in PWM, delay in one-shot, capture result in capture
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			mdata_q <= tcp_pkg::DATA_RST;
		end else if (is_cap && state_q == tcp_pkg::ST_RUN && edge_seen) begin
			mdata_q <= mcount_q;
		end else if (wr_en && addr_hit(APB_REQ.paddr, tcp_pkg::OFF_MDATA)) begin
			mdata_q <= APB_REQ.pwdata[15:0];
		end
	end

	// ------------------------------------------------------------------------
	// Master state machine
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			state_q <= tcp_pkg::ST_IDLE;
		end else if (stop_wr) begin
			state_q <= tcp_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				tcp_pkg::ST_IDLE: begin
					if (start_wr) begin
						state_q <= tcp_pkg::ST_RUN;
					end
				end
				tcp_pkg::ST_WAIT: begin
					if (start_wr || edge_seen) begin
						state_q <= tcp_pkg::ST_RUN;
					end
				end
				tcp_pkg::ST_RUN: begin
					if (is_one && mtick && m_zero) begin
						state_q <= tcp_pkg::ST_WAIT;
					end
				end
				default: begin
					state_q <= tcp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Master counter
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			mcount_q <= tcp_pkg::CNT_ZERO;
		end else if (stop_wr) begin
			mcount_q <= mcount_q;
		end else if (state_q == tcp_pkg::ST_IDLE && start_wr) begin
			mcount_q <= is_cap ? tcp_pkg::CNT_ZERO : mdata_q;
		end else if (state_q == tcp_pkg::ST_WAIT && (start_wr || edge_seen)) begin
			mcount_q <= mdata_q;
		end else if (state_q == tcp_pkg::ST_RUN) begin
			if (is_cap && edge_seen) begin
				mcount_q <= tcp_pkg::CNT_ZERO;
			end else if (is_cap && mtick) begin
				mcount_q <= mcount_q + tcp_pkg::CNT_ONE;
			end else if (mtick && m_zero) begin
				mcount_q <= is_pwm ? mdata_q : tcp_pkg::CNT_ZERO;
			end else if (mtick) begin
				mcount_q <= mcount_q - tcp_pkg::CNT_ONE;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Overflow tracking
	// ------------------------------------------------------------------------
	// Only one wrap is remembered; a second one is indistinguishable
	always_ff @(posedge CLOCK) begin
		// Reset and start both clear, so a new run never reports a stale wrap
		if (!RESETN || start_wr) begin
			ovf_run_q       <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else if (is_cap && state_q == tcp_pkg::ST_RUN) begin
			if (edge_seen) begin
				overflow_flag_q <= ovf_run_q;
				ovf_run_q       <= 1'b0;
			end else if (mtick && mcount_q == tcp_pkg::CNT_MAX) begin
				ovf_run_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Slave counter and output
	// ------------------------------------------------------------------------
	// End of a master period, or of the one-shot delay
	logic master_end;
	assign master_end = state_q == tcp_pkg::ST_RUN && mtick
		&& m_zero && !is_cap;

	always_ff @(posedge CLOCK) begin
		if (!RESETN || stop_wr) begin
			scount_q       <= tcp_pkg::CNT_ZERO;
			slave_run_q    <= 1'b0;
			slave_active_q <= 1'b0;
		end else if (is_pwm && state_q == tcp_pkg::ST_IDLE && start_wr) begin
			scount_q       <= sdata_q;
			slave_run_q    <= 1'b1;
			slave_active_q <= 1'b1;
		end else if (master_end) begin
			scount_q       <= sdata_q;
			slave_run_q    <= 1'b1;
			slave_active_q <= (sdata_q != tcp_pkg::CNT_ZERO) || is_pwm;
		end else if (slave_run_q && stick) begin
			if (is_pwm && s_zero) begin
				slave_run_q    <= 1'b0;
				slave_active_q <= 1'b0;
			end else if (is_one && scount_q <= tcp_pkg::CNT_ONE) begin
				scount_q       <= tcp_pkg::CNT_ZERO;
				slave_run_q    <= 1'b0;
				slave_active_q <= 1'b0;
			end else begin
				scount_q <= scount_q - tcp_pkg::CNT_ONE;
			end
		end
	end

	assign TIMER_OUT_EN = out_enable_q;
	assign TIMER_OUT    = out_enable_q ? (slave_active_q ^ polarity_q) : out_level_q;

	// ------------------------------------------------------------------------
	// Event pulses
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			mirq_q <= 1'b0;
			sirq_q <= 1'b0;
		end else begin
			mirq_q <= (state_q == tcp_pkg::ST_IDLE && start_wr
					&& (is_pwm || (is_cap && cfg_q.start_irq)))
				|| (is_cap && state_q == tcp_pkg::ST_RUN && edge_seen)
				|| master_end;
			sirq_q <= is_pwm && slave_run_q && stick
				&& s_zero;
		end
	end

	assign MASTER_IRQ = mirq_q;
	assign SLAVE_IRQ  = sirq_q;

	// ------------------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------------------
	// Read data captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			rdata_q  <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (rd_setup) begin
			slverr_q <= !mapped;
			rdata_q  <= 32'h0000_0000;
			unique case (APB_REQ.paddr)
				tcp_pkg::OFF_PERIPH_EN: rdata_q[0] <= unit_clock_enable_q;
				tcp_pkg::OFF_START_TRIG: begin
					rdata_q[tcp_pkg::MASTER_IDX] <= state_q != tcp_pkg::ST_IDLE;
					rdata_q[tcp_pkg::SLAVE_IDX]  <= slave_run_q;
				end
				tcp_pkg::OFF_MODE:    rdata_q[13:0] <= 14'(cfg_q);
				tcp_pkg::OFF_MDATA:   rdata_q[15:0] <= mdata_q;
				tcp_pkg::OFF_SDATA:   rdata_q[15:0] <= sdata_q;
				tcp_pkg::OFF_MCOUNT:  rdata_q[15:0] <= mcount_q;
				tcp_pkg::OFF_SCOUNT:  rdata_q[15:0] <= scount_q;
				tcp_pkg::OFF_OUTCTRL: begin
					rdata_q[tcp_pkg::OLVL_BIT] <= out_level_q;
					rdata_q[tcp_pkg::OEN_BIT]  <= out_enable_q;
					rdata_q[tcp_pkg::OPOL_BIT] <= polarity_q;
				end
				tcp_pkg::OFF_STATUS: begin
					rdata_q[0] <= overflow_flag_q;
					rdata_q[1] <= slave_active_q;
					rdata_q[4:2] <= state_q;
				end
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign APB_RSP.pready  = 1'b1;
	assign APB_RSP.pslverr = slverr_q && APB_REQ.psel && APB_REQ.penable;
	assign APB_RSP.prdata  = rdata_q;

endmodule

// ---- verification/tcp_checker.sv ----
// Port-level assertions for the timer channel pair
`timescale 1ns/100ps

module tcp_checker (
	input wire logic                  CLOCK,
	input wire logic                  RESETN,
	input wire tcp_pkg::tcp_apb_req_t APB_REQ,
	input wire tcp_pkg::tcp_apb_rsp_t APB_RSP,
	input wire logic                  SUB_TICK,
	input wire logic                  LOW_TICK,
	input wire logic                  TIMER_IN,
	input wire logic                  TIMER_OUT,
	input wire logic                  TIMER_OUT_EN,
	input wire logic                  MASTER_IRQ,
	input wire logic                  SLAVE_IRQ
);
	// ---------------------------------------------------------------
	// Register mirrors
	// ---------------------------------------------------------------
	logic       wr;
	logic       st;
	logic       ow;
	logic       lvl;
	logic       oen;
	logic       en_q;
	logic       sirq_q;
	logic [1:0] mode_q;
	assign wr  = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	assign st  = wr && APB_REQ.paddr == tcp_pkg::OFF_START_TRIG && |APB_REQ.pwdata[5:4];
	assign ow  = wr && APB_REQ.paddr == tcp_pkg::OFF_OUTCTRL;
	assign lvl = APB_REQ.pwdata[0];
	assign oen = APB_REQ.pwdata[1];
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			en_q <= 1'b0;
		end else if (wr && APB_REQ.paddr == tcp_pkg::OFF_PERIPH_EN) begin
			en_q <= APB_REQ.pwdata[0];
		end
	end
	// Mode writes are only made while idle, so the mirror stays exact
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			mode_q <= 2'h0;
			sirq_q <= 1'b0;
		end else if (wr && APB_REQ.paddr == tcp_pkg::OFF_MODE) begin
			mode_q <= APB_REQ.pwdata[1:0];
			sirq_q <= APB_REQ.pwdata[2];
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	ready_const_a: assert property (APB_RSP.pready)
		else $error("pready dropped");
	mirq_pulse_a: assert property (MASTER_IRQ |=> !MASTER_IRQ)
		else $error("master irq longer than one cycle");
	sirq_pulse_a: assert property (SLAVE_IRQ |=> !SLAVE_IRQ)
		else $error("slave irq longer than one cycle");
	level_follow_a: assert property (ow && !oen && !TIMER_OUT_EN |=>
		!TIMER_OUT_EN && TIMER_OUT == $past(lvl)) else $error("pin not at level bit");
	oen_write_a: assert property (ow |=> TIMER_OUT_EN == $past(oen))
		else $error("output enable not written");
	unit_off_a: assert property (!en_q && !$past(en_q) |-> !MASTER_IRQ && !SLAVE_IRQ)
		else $error("irq while unit disabled");
	start_irq_a: assert property (st && en_q && (mode_q == tcp_pkg::MD_PWM ||
		(mode_q == tcp_pkg::MD_CAPTURE && sirq_q)) |-> ##[1:3] MASTER_IRQ)
		else $error("no irq at start");
	quiet_start_a: assert property (st && en_q && mode_q == tcp_pkg::MD_CAPTURE &&
		!sirq_q |=> !MASTER_IRQ [*3]) else $error("start irq not selected");
	sirq_mode_a: assert property (SLAVE_IRQ |-> mode_q == tcp_pkg::MD_PWM)
		else $error("slave irq outside pwm mode");
	cover property (st && en_q && mode_q == tcp_pkg::MD_ONESHOT);
	cover property (SLAVE_IRQ);
	cover property (TIMER_OUT_EN && $rose(TIMER_OUT));
endmodule

bind tcp_timer tcp_checker tcp_checker_inst (
	.CLOCK(CLOCK), .RESETN(RESETN), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.SUB_TICK(SUB_TICK), .LOW_TICK(LOW_TICK), .TIMER_IN(TIMER_IN), .TIMER_OUT(TIMER_OUT),
	.TIMER_OUT_EN(TIMER_OUT_EN), .MASTER_IRQ(MASTER_IRQ), .SLAVE_IRQ(SLAVE_IRQ)
);

// ---- verification/tcp_pin_model.sv ----
// Far-side pins: pulse source on the timer input, pulse meter on the output
`timescale 1ns/100ps

module tcp_pin_model (
	input  wire logic        clk,
	input  wire logic [15:0] gap,
	input  wire logic        rise,
	input  wire logic        act,
	input  wire logic        per_sel,
	output logic             pin,
	output logic [15:0]      len,
	output logic             vld
);
	logic [15:0] gcnt = 16'h0000;
	logic [15:0] hcnt = 16'h0000;
	logic [15:0] pcnt = 16'h0000;
	logic [15:0] prd  = 16'h0000;
	logic        act_q = 1'b0;
	initial begin
		pin = 1'b1;
		len = 16'h0000;
		vld = 1'b0;
	end
	// One-cycle pulse of the valid level every gap cycles; gap 0 keeps it idle
	always @(posedge clk) begin
		gcnt <= (gap == 16'h0000 || gcnt >= gap - 16'h0001) ? 16'h0000 : gcnt + 16'h0001;
		pin  <= (gap != 16'h0000 && gcnt == gap - 16'h0001) ? rise : !rise;
	end
	// Width ends at the fall of act; period runs rise to rise
	always @(posedge clk) begin
		act_q <= act;
		vld   <= act_q && !act;
		hcnt  <= act ? hcnt + 16'h0001 : 16'h0000;
		pcnt  <= (act && !act_q) ? 16'h0001 : pcnt + 16'h0001;
		if (act && !act_q) prd <= pcnt;
		if (act_q && !act) len <= per_sel ? prd : hcnt;
	end
endmodule

// ---- verification/tcp_timer_test.sv ----
// Self-checking bench for the timer channel pair
`timescale 1ns/100ps

module tcp_timer_test;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	tcp_pkg::tcp_apb_req_t apb_req = '0;
	tcp_pkg::tcp_apb_rsp_t apb_rsp;
	logic                  sub_tick = 1'b0;
	logic                  low_tick = 1'b0;
	logic                  timer_in;
	logic                  timer_out;
	logic                  timer_out_en;
	logic                  master_irq;
	logic                  slave_irq;
	logic                  pol = 1'b0;
	logic                  per_sel = 1'b0;
	logic                  rise = 1'b0;
	logic                  vld;
	logic [15:0]           gap = 16'h0000;
	logic [15:0]           len;
	logic [4:0]            src = 5'h00;
	logic [32:0]           rd_q[$];
	logic [32:0]           ms_q[$];
	int                    bad_count = 0;
	int                    tests_run = 0;
	int                    cyc = 0;
	int                    k, m, s, w, d;

	always #4 clk = ~clk;

	tcp_timer tcp_timer_inst (.CLOCK(clk), .RESETN(rst_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
		.SUB_TICK(sub_tick), .LOW_TICK(low_tick), .TIMER_IN(timer_in), .TIMER_OUT(timer_out),
		.TIMER_OUT_EN(timer_out_en), .MASTER_IRQ(master_irq), .SLAVE_IRQ(slave_irq));
	tcp_pin_model tcp_pin_model_inst (.clk(clk), .gap(gap), .rise(rise), .act(timer_out ^ pol),
		.per_sel(per_sel), .pin(timer_in), .len(len), .vld(vld));

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One idle cycle after each transfer keeps psel from two writes in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: dat};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (apb_rsp.pready !== 1'b1);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// Random tick enables: a wrong source pick shows up as a wrong width
	always @(posedge clk) begin
		sub_tick <= src == 5'h10 || $urandom % 2 == 1;
		low_tick <= src == 5'h11 || $urandom % 2 == 1;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (apb_req.psel && apb_req.penable && !apb_req.pwrite && rd_q.size() > 0)
			chk({apb_rsp.pslverr, apb_rsp.prdata}, rd_q.pop_front());
		if (vld === 1'b1 && ms_q.size() > 0)
			chk({17'h0_0000, len}, ms_q.pop_front());
		if (cyc == 80000) begin
			bad_count++;
			conclude();
		end
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h8804_0ef1));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(tcp_pkg::OFF_MDATA, 33'h0_0000_FFFF);
		rd(tcp_pkg::OFF_SDATA, 33'h0_0000_FFFF);
		rd(tcp_pkg::OFF_STATUS, 33'h0_0000_0004);
		rd(8'h28, 33'h1_0000_0000);
		apb(1'b1, tcp_pkg::OFF_MODE, 32'h0000_0001);
		apb(1'b1, tcp_pkg::OFF_START_TRIG, 32'h0000_0010);
		rd(tcp_pkg::OFF_START_TRIG, 33'h0_0000_0000);
		apb(1'b1, tcp_pkg::OFF_OUTCTRL, 32'h0000_0001);
		chk({31'h0, timer_out_en, timer_out}, 33'h0_0000_0001);
		apb(1'b1, tcp_pkg::OFF_PERIPH_EN, 32'h0000_0001);
		$display("reset and disabled unit done");
		// Second pass idles past one wrap before its first edge
		for (int i = 0; i < 2; i++) begin
			k = 20 + $urandom % 100;
			rise <= i[0];
			apb(1'b1, tcp_pkg::OFF_MODE, {28'h0, i[0], i[0], 2'h0});
			apb(1'b1, tcp_pkg::OFF_START_TRIG, 32'h0000_0010);
			repeat (i ? 65540 : 10) @(posedge clk);
			gap <= 16'(k);
			@(posedge clk iff master_irq === 1'b1);
			rd(tcp_pkg::OFF_STATUS, {28'h0, 4'h8, i[0]});
			repeat (2) @(posedge clk iff master_irq === 1'b1);
			rd(tcp_pkg::OFF_MDATA, 33'(k - 1));
			rd(tcp_pkg::OFF_STATUS, 33'h0_0000_0010);
			gap <= 16'h0000;
			apb(1'b1, tcp_pkg::OFF_STOP_TRIG, 32'h0000_0010);
			rd(tcp_pkg::OFF_STATUS, 33'h0_0000_0004);
		end
		$display("capture done");
		for (int p = 0; p < 2; p++) begin
			m = 3 + $urandom % 20;
			s = 1 + $urandom % (m - 1);
			pol <= p[0];
			per_sel <= 1'b1;
			apb(1'b1, tcp_pkg::OFF_MDATA, 32'(m));
			apb(1'b1, tcp_pkg::OFF_SDATA, 32'(s));
			apb(1'b1, tcp_pkg::OFF_OUTCTRL, {29'h0, p[0], 2'b10});
			apb(1'b1, tcp_pkg::OFF_MODE, 32'h0000_0211);
			apb(1'b1, tcp_pkg::OFF_START_TRIG, 32'h0000_0020);
			chk({32'h0000_0000, timer_out}, {32'h0000_0000, !p[0]});
			repeat (3) @(posedge clk iff vld === 1'b1);
			@(posedge clk);
			ms_q.push_back(33'(2 * (m + 1)));
			@(posedge clk iff vld === 1'b1);
			apb(1'b1, tcp_pkg::OFF_STOP_TRIG, 32'h0000_0010);
			rd(tcp_pkg::OFF_SCOUNT, 33'h0_0000_0000);
		end
		$display("pwm done");
		for (int j = 0; j < 3; j++) begin
			w = 2 + $urandom % 30;
			d = 5 + $urandom % 30;
			pol <= 1'b0;
			per_sel <= 1'b0;
			rise <= 1'b1;
			src <= j == 0 ? 5'h00 : 5'(15 + j);
			apb(1'b1, tcp_pkg::OFF_MDATA, 32'(d));
			apb(1'b1, tcp_pkg::OFF_SDATA, 32'(w));
			apb(1'b1, tcp_pkg::OFF_OUTCTRL, 32'h0000_0002);
			apb(1'b1, tcp_pkg::OFF_MODE, {18'h0, 5'(j == 0 ? 0 : 15 + j), 9'h00A});
			ms_q.push_back(33'(w));
			apb(1'b1, tcp_pkg::OFF_START_TRIG, 32'h0000_0010);
			@(posedge clk iff vld === 1'b1);
			ms_q.push_back(33'(w));
			gap <= 16'(d + w + 40);
			@(posedge clk iff vld === 1'b1);
			gap <= 16'h0000;
			rd(tcp_pkg::OFF_MCOUNT, 33'h0_0000_0000);
			apb(1'b1, tcp_pkg::OFF_STOP_TRIG, 32'h0000_0010);
		end
		$display("one-shot done");
		conclude();
	end
endmodule
